//--- verilog/gsp_pkg.sv
// Package of constants for the positioning module serial port
package gsp_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned SECOND_CYCLES = CLK_HZ;
  localparam int unsigned PULSE_MS = 100;
  localparam int unsigned PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned RATE_DEFAULT_HZ = 1;
  localparam int unsigned RATE_MAX_HZ = 10;
  localparam logic [7:0] CHAR_DOLLAR = 8'h24;
  localparam logic [7:0] CHAR_STAR = 8'h2a;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [7:0] CMD_STANDBY = 8'h53;
  localparam logic [7:0] CMD_PERIODIC = 8'h50;
  localparam logic [7:0] CMD_RATE = 8'h52;
  localparam logic [7:0] CMD_HOT = 8'h48;
  localparam logic [1:0] START_COLD = 2'h0;
  localparam logic [1:0] START_HOT = 2'h1;
  typedef enum logic [2:0] {
    GSP_RUN = 3'b001,
    GSP_STANDBY = 3'b010,
    GSP_PERIODIC_SLEEP = 3'b100
  } gsp_power_t;
endpackage

//--- verilog/gsp_link_if.sv
// Interface carrying one transmit-byte request from the main module to the serialiser
`timescale 1ns/1ps
`default_nettype none
interface gsp_link_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- verilog/gsp_tx.sv
// Frame serialiser: idle high, start low, 8 data lsb first, one stop
`timescale 1ns/1ps
`default_nettype none
module gsp_tx import gsp_pkg::*; #(
  parameter int unsigned BIT_CYC = gsp_pkg::BIT_CYCLES
) (
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset
  gsp_link_if.dst link, // Byte request
  output logic line // Serial line, registered
);
  logic [9:0] shreg;
  logic [3:0] bits_left;
  logic [17:0] tick;
  wire busy = (bits_left != 4'h0);
  wire bit_end = (tick == 18'(BIT_CYC - 1));
  assign link.ready = !busy;
  // Shift one bit per bit time; start bit leads, stop bit trails
  always_ff @(posedge clk) begin
    if (rst) begin
      shreg <= 10'h3ff;
      bits_left <= 4'h0;
      tick <= 18'h0;
      line <= 1'b1;
    end else if (!busy) begin
      tick <= 18'h0;
      line <= 1'b1;
      if (link.valid) begin
        shreg <= {1'b1, link.data, 1'b0};
        bits_left <= 4'ha;
      end
    end else begin
      line <= shreg[0];
      tick <= bit_end ? 18'h0 : tick + 18'h1;
      if (bit_end) begin
        shreg <= {1'b1, shreg[9:1]};
        bits_left <= bits_left - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/gsp_top.sv
// Serial port, second pulse and power behaviour of the positioning module
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - One full-duplex channel, separate in and out lines usable together.
// - Frames are eight data bits, no parity, one stop bit only.
// - Data bits travel least significant first both ways.
// - Link runs at 9600 bit/s after start unless reconfigured.
// - Drive a pulse each second, rising edge marks the second start.
// - Standby command on the receive line puts the module in standby; during periodic sleep the logic wakes to run instead.
// - Any received byte in standby resumes normal operation.
// - Periodic command alternates run and standby intervals unaided.
// - Updates at 1 Hz by default, up to 10 Hz when configured.
// - Cold start without backup supply, hot start when backup retained.
// - Output records are ASCII, open with dollar, checksum, end CR LF.
module gsp_top import gsp_pkg::*; #(
  parameter int unsigned BIT_CYC = gsp_pkg::BIT_CYCLES,
  parameter int unsigned SEC_CYC = gsp_pkg::SECOND_CYCLES,
  parameter int unsigned PULSE_CYC = gsp_pkg::PULSE_CYCLES,
  parameter int unsigned RUN_SECONDS = 4,
  parameter int unsigned SLEEP_SECONDS = 4
) (
  input wire logic CLK, // 250 MHz clock
  input wire logic RST, // Synchronous reset, high
  input wire logic MODULE_SERIAL_IN, // Receive line from host
  input wire logic BACKUP_SUPPLY_PIN, // High when backup domain held
  output logic MODULE_SERIAL_OUT, // Transmit line to host
  output logic SECOND_PULSE_OUT, // Pulse per second
  output logic STANDBY, // High while in low power
  output logic HOT_START // Start kind caught after reset
);
  // Counter widths sized for the defaults
  localparam int unsigned CW = 28;

  gsp_link_if link();
  logic tx_line;

  // Receiver state
  logic [17:0] rx_tick;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_busy;
  logic rx_done;
  logic [7:0] rx_byte;

  wire rx_mid = (rx_tick == 18'(BIT_CYC / 2 - 1));
  wire rx_end = (rx_tick == 18'(BIT_CYC - 1));

  // Sampling at mid-bit; a start bit that is gone at mid-bit is a glitch
  always_ff @(posedge CLK) begin
    rx_done <= 1'b0;
    if (RST) begin
      rx_tick <= 18'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_busy <= 1'b0;
      rx_byte <= 8'h00;
    end else if (!rx_busy) begin
      rx_tick <= 18'h0;
      rx_bit <= 4'h0;
      if (!MODULE_SERIAL_IN) begin
        rx_busy <= 1'b1;
      end
    end else begin
      rx_tick <= rx_end ? 18'h0 : rx_tick + 18'h1;
      if (rx_end) begin
        rx_bit <= rx_bit + 4'h1;
      end
      if (rx_mid) begin
        if (rx_bit == 4'h0 && MODULE_SERIAL_IN) begin
          rx_busy <= 1'b0;
        end else if (rx_bit >= 4'h1 && rx_bit <= 4'(DATA_BITS)) begin
          rx_shift <= {MODULE_SERIAL_IN, rx_shift[7:1]};
        end else if (rx_bit == 4'(DATA_BITS + STOP_BITS)) begin
          rx_busy <= 1'b0;
          // Framing error drops the byte; no parity exists to check
          if (MODULE_SERIAL_IN) begin
            rx_done <= 1'b1;
            rx_byte <= rx_shift;
          end
        end
      end
    end
  end

  // Second timebase and update timebase
  logic [CW-1:0] sec_cnt;
  logic [CW-1:0] upd_cnt;
  logic [3:0] rate_hz;
  logic [3:0] run_secs;
  wire sec_wrap = (sec_cnt == CW'(SEC_CYC - 1));
  wire [CW-1:0] upd_period = CW'(SEC_CYC / rate_hz);
  wire upd_tick = (upd_cnt >= upd_period - CW'(1));

  // Power state machine
  gsp_power_t state;
  gsp_power_t next_state;
  logic [3:0] sleep_secs;
  wire cmd_stby = rx_done && rx_byte == CMD_STANDBY;
  wire cmd_per = rx_done && rx_byte == CMD_PERIODIC;
  wire cmd_rate = rx_done && rx_byte == CMD_RATE;

  always_comb begin
    next_state = state;
    unique case (state)
      GSP_RUN: begin
        if (cmd_stby) begin
          next_state = GSP_STANDBY;
        end else if (run_secs != 4'h0 && run_secs == 4'(RUN_SECONDS) && sec_wrap) begin
          next_state = GSP_PERIODIC_SLEEP;
        end
      end
      GSP_STANDBY: begin
        if (rx_done) begin
          next_state = GSP_RUN;
        end
      end
      GSP_PERIODIC_SLEEP: begin
        if (rx_done) begin
          next_state = GSP_RUN;
        end else if (sleep_secs == 4'(SLEEP_SECONDS) && sec_wrap) begin
          next_state = GSP_RUN;
        end
      end
    endcase
  end

  // Periodic flag: run_secs zero means continuous operation
  logic periodic;
  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= GSP_RUN;
      periodic <= 1'b0;
      run_secs <= 4'h0;
      sleep_secs <= 4'h0;
      rate_hz <= 4'(RATE_DEFAULT_HZ);
    end else begin
      state <= next_state;
      if (cmd_per && state == GSP_RUN) begin
        periodic <= 1'b1;
      end else if (cmd_stby || (rx_done && state == GSP_STANDBY)) begin
        periodic <= 1'b0;
      end
      // Rate command cycles 1..10 Hz; simple stand-in for config sentences
      if (cmd_rate && state == GSP_RUN) begin
        rate_hz <= (rate_hz == 4'(RATE_MAX_HZ)) ? 4'(RATE_DEFAULT_HZ) : rate_hz + 4'h1;
      end
      if (next_state != state) begin
        run_secs <= (next_state == GSP_RUN && periodic) ? 4'h1 : 4'h0;
        sleep_secs <= 4'h1;
      end else if (sec_wrap) begin
        // A periodic command landing on a wrap must still start the run count
        if (state == GSP_RUN && (periodic || cmd_per)) begin
          run_secs <= run_secs + 4'h1;
        end
        sleep_secs <= sleep_secs + 4'h1;
      end else if (cmd_per && state == GSP_RUN) begin
        run_secs <= 4'h1;
      end
    end
  end

  // Second pulse keeps running in standby so timing is never lost
  always_ff @(posedge CLK) begin
    if (RST) begin
      sec_cnt <= CW'(SEC_CYC - 1); // Wraps on first edge so the first pulse is full width
      SECOND_PULSE_OUT <= 1'b0;
    end else begin
      sec_cnt <= sec_wrap ? '0 : sec_cnt + CW'(1);
      SECOND_PULSE_OUT <= (sec_wrap || sec_cnt < CW'(PULSE_CYC - 1));
    end
  end

  // Start kind caught after reset release, never in the reset branch
  logic start_kind_valid;
  always_ff @(posedge CLK) begin
    if (RST) begin
      start_kind_valid <= 1'b0;
      HOT_START <= 1'b0;
    end else if (!start_kind_valid) begin
      start_kind_valid <= 1'b1;
      HOT_START <= BACKUP_SUPPLY_PIN;
    end
  end

  // Record generator: "$G<kind>*<sum>\r\n" per update tick in run state
  logic [2:0] rec_idx;
  logic [7:0] csum;
  logic rec_active;
  function automatic logic [7:0] hex_char(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction
  logic [7:0] rec_char;
  always_comb begin
    unique case (rec_idx)
      3'h0: rec_char = CHAR_DOLLAR;
      3'h1: rec_char = 8'h47;
      3'h2: rec_char = HOT_START ? CMD_HOT : 8'h43;
      3'h3: rec_char = CHAR_STAR;
      3'h4: rec_char = hex_char(csum[7:4]);
      3'h5: rec_char = hex_char(csum[3:0]);
      3'h6: rec_char = CHAR_CR;
      default: rec_char = CHAR_LF;
    endcase
  end
  // Characters leave only in run state; standby drops the rest of a record
  wire rec_go = rec_active && state == GSP_RUN;
  assign link.valid = rec_go;
  assign link.data = rec_char;
  wire take = rec_go && link.ready;

  always_ff @(posedge CLK) begin
    if (RST) begin
      upd_cnt <= '0;
      rec_active <= 1'b0;
      rec_idx <= 3'h0;
      csum <= 8'h00;
    end else begin
      upd_cnt <= upd_tick ? '0 : upd_cnt + CW'(1);
      if (!rec_active && upd_tick && state == GSP_RUN) begin
        rec_active <= 1'b1;
        rec_idx <= 3'h0;
        csum <= 8'h00;
      end else if (take) begin
        // Checksum covers the characters between dollar and star
        if (rec_idx == 3'h1 || rec_idx == 3'h2) begin
          csum <= csum ^ rec_char;
        end
        rec_idx <= rec_idx + 3'h1;
        if (rec_idx == 3'h7) begin
          rec_active <= 1'b0;
        end
      end else if (state != GSP_RUN) begin
        rec_active <= 1'b0;
      end
    end
  end

  // Transmit runs alongside receive; the channel is full duplex
  gsp_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(CLK),
    .rst(RST),
    .link(link),
    .line(tx_line)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      MODULE_SERIAL_OUT <= 1'b1;
      STANDBY <= 1'b0;
    end else begin
      MODULE_SERIAL_OUT <= tx_line;
      STANDBY <= (state != GSP_RUN);
    end
  end
endmodule
`default_nettype wire

//--- test/gsp_top_assertions.sv
// Checker for the transmit line, second pulse and start-kind pins
`timescale 1ns/1ps
`default_nettype none
module gsp_top_assertions #(
  parameter int unsigned BIT_CYC = 8,
  parameter int unsigned SEC_CYC = 8000,
  parameter int unsigned PULSE_CYC = 100
) (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire logic MODULE_SERIAL_OUT, // Transmit line
  input wire logic SECOND_PULSE_OUT, // Second pulse
  input wire logic STANDBY, // Low power flag
  input wire logic HOT_START // Start kind
);
  localparam int BC1 = BIT_CYC - 1;
  localparam int STOPD = 9 * BIT_CYC;
  localparam int PW1 = PULSE_CYC - 1;
  logic out_q;
  logic pul_q;
  logic seen;
  int txc;
  int gap;
  wire logic fs = txc == 0 && out_q && !MODULE_SERIAL_OUT;
  wire logic rise = SECOND_PULSE_OUT && !pul_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Frame span and second spacing; first rise after reset has no reference
  always_ff @(posedge CLK) begin
    out_q <= RST | MODULE_SERIAL_OUT;
    pul_q <= !RST & SECOND_PULSE_OUT;
    seen <= !RST & (seen | rise);
    txc <= RST ? 0 : fs ? 10 * BIT_CYC - 1 : txc != 0 ? txc - 1 : 0;
    gap <= (RST || rise) ? 1 : gap + 1;
  end
  AST_PULSE_WIDTH: assert property (rise |-> ##PW1 SECOND_PULSE_OUT ##1 !SECOND_PULSE_OUT)
    else $error("pulse width wrong");
  AST_PULSE_PERIOD: assert property (rise && seen |-> gap == SEC_CYC)
    else $error("pulse period wrong");
  AST_START_BIT: assert property (fs |-> ##BC1 !MODULE_SERIAL_OUT)
    else $error("start bit short");
  AST_STOP_BIT: assert property (fs |-> ##STOPD MODULE_SERIAL_OUT ##BC1 MODULE_SERIAL_OUT)
    else $error("stop bit missing");
  AST_BIT_HOLD: assert property (txc != 0 && txc % BIT_CYC != 0 |-> $stable(MODULE_SERIAL_OUT))
    else $error("bit changed inside its cell");
  AST_IDLE_HIGH: assert property (txc == 0 && !out_q |-> MODULE_SERIAL_OUT)
    else $error("line low while idle");
  AST_QUIET_STANDBY: assert property ($past(STANDBY, 3) && STANDBY |-> !fs)
    else $error("frame started in standby");
  AST_HOT_HOLD: assert property (!$past(RST) && !$past(RST, 2) |-> $stable(HOT_START))
    else $error("start kind changed");
endmodule
`default_nettype wire

//--- test/gsp_host_model.sv
// Host serial port: sends frames, collects received bytes with times
`timescale 1ns/1ps
`default_nettype none
module gsp_host_model #(
  parameter int unsigned BIT_CYC = 8
) (
  input wire logic clk, // Bench clock
  input wire logic line_in, // From module transmit
  output logic line_out // To module receive
);
  logic [7:0] rx_q[$];
  time rx_t[$];
  int n_bad = 0;
  logic [7:0] b;
  initial line_out = 1'b1; // Idle high as with the pull-up
  // Start low, data lsb first, one stop; changes at falling edges
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      line_out = f[i];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask
  // Mid-bit sampling; a low stop bit is counted, not kept
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (line_in === 1'b1) begin
      rx_q.push_back(b);
      rx_t.push_back($time);
    end else begin
      n_bad++;
    end
  end
endmodule
`default_nettype wire

//--- test/gsp_top_bench.sv
// Bench for the positioning module serial port
`timescale 1ns/1ps
`default_nettype none
module gsp_top_bench;
  import gsp_pkg::*;
  localparam int unsigned BIT_CYC = 8;
  localparam int unsigned SEC_CYC = 8000;
  localparam int unsigned PULSE_CYC = 100;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic backup = 1'b1;
  logic ser_in;
  logic ser_out;
  logic standby;
  logic hot;
  logic pulse;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  gsp_top #(.BIT_CYC(BIT_CYC), .SEC_CYC(SEC_CYC), .PULSE_CYC(PULSE_CYC), .RUN_SECONDS(1), .SLEEP_SECONDS(1)) i_dut (
    .CLK(clk), .RST(rst), .MODULE_SERIAL_IN(ser_in), .BACKUP_SUPPLY_PIN(backup), .MODULE_SERIAL_OUT(ser_out),
    .SECOND_PULSE_OUT(pulse), .STANDBY(standby), .HOT_START(hot));
  gsp_host_model #(.BIT_CYC(BIT_CYC)) i_host (.clk(clk), .line_in(ser_out), .line_out(ser_in));
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Drop bytes until a record opener arrives, bounded by three seconds
  task automatic wait_rec(output time t);
    for (int k = 0; k < 3 * SEC_CYC; k++) begin
      @(negedge clk);
      if (i_host.rx_q.size() > 0) begin
        t = i_host.rx_t.pop_front();
        if (i_host.rx_q.pop_front() === CHAR_DOLLAR)
          return;
      end
    end
    t = 0;
  endtask
  // Spacing of the last two of three records, in clock cycles
  task automatic gap_chk(input int unsigned exp);
    time a;
    time b;
    wait_rec(a);
    wait_rec(a);
    wait_rec(b);
    chk(32'((b - a) / 4), exp);
  endtask
  task automatic t_start(input logic bk, input logic [7:0] kind);
    logic [7:0] cs;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] exp[7];
    time t;
    @(negedge clk);
    rst = 1'b1;
    backup = bk;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(hot, bk);
    chk(ser_out, 1'b1);
    chk(standby, 1'b0);
    chk(pulse, 1'b1);
    // A frame cut by the reset may still be arriving; let it land, then forget it
    repeat (100) @(negedge clk);
    i_host.rx_q.delete();
    i_host.rx_t.delete();
    cs = 8'h47 ^ kind;
    // Checksum digits are upper-case hex
    hi = (cs[7:4] < 4'ha) ? 8'h30 + 8'(cs[7:4]) : 8'h41 + 8'(cs[7:4]) - 8'h0a;
    lo = (cs[3:0] < 4'ha) ? 8'h30 + 8'(cs[3:0]) : 8'h41 + 8'(cs[3:0]) - 8'h0a;
    exp = '{8'h47, kind, CHAR_STAR, hi, lo, CHAR_CR, CHAR_LF};
    wait_rec(t);
    repeat (88 * BIT_CYC) @(negedge clk);
    for (int i = 0; i < 7; i++)
      chk(i_host.rx_q[i], exp[i]);
  endtask
  task automatic t_rate;
    gap_chk(SEC_CYC);
    i_host.send(CMD_RATE);
    gap_chk(SEC_CYC / 2);
    repeat (8) i_host.send(CMD_RATE);
    gap_chk(SEC_CYC / 10);
  endtask
  task automatic wait_sb(input logic v);
    for (int k = 0; k < 3 * SEC_CYC && standby !== v; k++)
      @(negedge clk);
    chk(standby, v);
  endtask
  // Quiet line in standby, then an arbitrary byte wakes it
  task automatic t_standby;
    time t;
    i_host.send(CMD_STANDBY);
    repeat (2) @(negedge clk);
    chk(standby, 1'b1);
    repeat (700) @(negedge clk);
    i_host.rx_q.delete();
    i_host.rx_t.delete();
    repeat (SEC_CYC) @(negedge clk);
    chk(i_host.rx_q.size(), 0);
    i_host.send(8'ha5);
    repeat (2) @(negedge clk);
    chk(standby, 1'b0);
    wait_rec(t);
    chk(t != 0, 1'b1);
  endtask
  task automatic t_periodic;
    i_host.send(CMD_PERIODIC);
    wait_sb(1'b1);
    wait_sb(1'b0);
    wait_sb(1'b1);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      conclude();
    end
  end
  initial begin
    t_start(1'b1, CMD_HOT);
    t_rate();
    t_standby();
    t_periodic();
    t_start(1'b0, 8'h43);
    chk(i_host.n_bad, 0);
    conclude();
  end
endmodule
bind gsp_top gsp_top_assertions #(.BIT_CYC(BIT_CYC), .SEC_CYC(SEC_CYC), .PULSE_CYC(PULSE_CYC)) i_chk (
  .CLK(CLK), .RST(RST), .MODULE_SERIAL_OUT(MODULE_SERIAL_OUT), .SECOND_PULSE_OUT(SECOND_PULSE_OUT),
  .STANDBY(STANDBY), .HOT_START(HOT_START));
`default_nettype wire
